// ===== verilog/dasr_pkg.sv
package dasr_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int RES_W      = 12;           // One converter result
  localparam int WORD_W     = 2 * RES_W;    // Result pair as buffered
  localparam int PAIR_W     = 3;            // Channel pair select width
  localparam int FIFO_DEPTH = 8;            // Result pairs held in buffer
  localparam int IDX_W      = 4;            // Bit index inside one 16-bit slot
  localparam int SYNC_W     = 2;            // Flip-flops per synchroniser

  // ----------------------------------------------------------------------
  // Serial frame layout, counted in falling serial clock edges
  // ----------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_START = 4'h1;  // Index after first edge
  localparam logic [IDX_W-1:0] IDX_MSB   = 4'h2;  // After two leading zeros
  localparam logic [IDX_W-1:0] IDX_LSB   = 4'hd;  // Last result bit
  localparam logic [IDX_W-1:0] IDX_DONE  = 4'he;  // 14 clocks: result complete
  localparam logic [IDX_W-1:0] IDX_LAST  = 4'hf;  // End of a 16-clock slot

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [WORD_W-1:0] HOLD_RST = 24'h000000;
  localparam logic [PAIR_W-1:0] PAIR_RST = 3'h0;

  // ----------------------------------------------------------------------
  // Link phase, Gray coded along the frame
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LK_IDLE   = 2'b00,
    LK_FIRST  = 2'b01,
    LK_SECOND = 2'b11,
    LK_TAIL   = 2'b10
  } dasr_link_e;

endpackage : dasr_pkg

// ===== verilog/dasr_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------------
// Result stream between the readout core and its buffer
// ------------------------------------------------------------------------
interface dasr_stream_if #(parameter int WIDTH = 24);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport fifo_mp (input wr_valid, wr_data, rd_ready,
                   output wr_ready, rd_valid, rd_data);
  modport user_mp (output wr_valid, wr_data, rd_ready,
                   input wr_ready, rd_valid, rd_data);
endinterface : dasr_stream_if

`default_nettype wire

// ===== verilog/dasr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO; DEPTH must be a power of two for pointer wrap
module dasr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Both stream sides
  dasr_stream_if.fifo_mp s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
    logic                        not_full;
    logic                        not_empty;
  } dasr_fifo_s;

  dasr_fifo_s st_reg;
  dasr_fifo_s st_next;
  logic       push;
  logic       pop;

  // Flags are registered so ready and valid leave from flip-flops
  always_comb begin
    st_next = st_reg;
    push    = s.wr_valid && st_reg.not_full;
    pop     = s.rd_ready && st_reg.not_empty;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = s.wr_data;
      st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    st_next.count     = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    st_next.not_full  = (st_next.count != FULL_CNT);
    st_next.not_empty = (st_next.count != '0);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.not_full <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s.wr_ready = st_reg.not_full;
  assign s.rd_valid = st_reg.not_empty;
  assign s.rd_data  = st_reg.mem[st_reg.rd_ptr];

endmodule : dasr_fifo

`default_nettype wire

// ===== verilog/dasr_readout.sv
// Overview of operation
// - Each new bit on both data outputs is launched by a falling serial clock edge.
// - Both converters' results leave together, one on each data output.
// - Each output word starts with two zero bits and then the 12 result bits.
// - The 12 result bits go out most significant bit first, least significant last.
// - With 16 clocks instead of 14 in the frame, two zero bits follow the result.
// - A further 16 clocks make each output carry the other converter's word next.
// - Once a conversion completes, the sampling stages return to tracking.
// - Straight binary codes run from all zeros at the bottom to all ones at the top.
// - Twos complement codes step from all ones to all zeros at midscale.
// - The first falling serial clock edge after frame select falls starts a conversion and samples; frame select frames the transfer.
// - The serial clock both shifts the data and steps the conversion.
// - The input configuration selects differential when low, single-ended when high.
`timescale 1ns/1ps
`default_nettype none

module dasr_readout (
  // System clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          sys_rst,
  // Serial link from the host
  input  wire logic                          link_sclk,
  input  wire logic                          cs_n,
  output logic                               dout_a,
  output logic                               dout_b,
  // Configuration pins
  input  wire logic [dasr_pkg::PAIR_W-1:0]   channel_pair_select,
  input  wire logic                          input_config_select,
  input  wire logic                          twos_comp_select,
  // Converter front end control
  output logic                               conv_start,
  output logic                               track_hold,
  output logic [dasr_pkg::PAIR_W-1:0]        conv_pair_sel,
  output logic                               conv_single_ended,
  // Converter results
  input  wire logic                          res_valid,
  output logic                               res_ready,
  input  wire logic [dasr_pkg::RES_W-1:0]    res_a,
  input  wire logic [dasr_pkg::RES_W-1:0]    res_b
);
  import dasr_pkg::*;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------

  // System side: synchronisers, front end control, word held for the link
  typedef struct packed {
    logic [SYNC_W-1:0] frm_sync;
    logic [SYNC_W-1:0] done_sync;
    logic              frm_seen;
    logic              done_seen;
    logic [PAIR_W-1:0] pair_s1;
    logic [PAIR_W-1:0] pair_s2;
    logic              cfg_s1;
    logic              cfg_s2;
    logic              coding_s1;
    logic              coding_s2;
    logic              conv_start;
    logic              track_hold;
    logic [PAIR_W-1:0] pair_out;
    logic              single_out;
    logic              hold_fresh;
    logic [WORD_W-1:0] hold_word;
  } dasr_ref_s;

  // Link side: one frame's worth of state, cleared while frame select is high
  typedef struct packed {
    dasr_link_e        phase;
    logic [IDX_W-1:0]  idx;
    logic [RES_W-1:0]  word_a;
    logic [RES_W-1:0]  word_b;
    logic              active;
    logic              done;
    logic              dout_a;
    logic              dout_b;
  } dasr_link_s;

  dasr_ref_s  ref_reg;
  dasr_ref_s  ref_next;
  dasr_link_s lk_reg;
  dasr_link_s lk_next;

  logic             frm_rise;
  logic             frm_fall;
  logic             done_rise;
  logic [RES_W-1:0] coded_a;
  logic [RES_W-1:0] coded_b;

  dasr_stream_if #(.WIDTH(WORD_W)) res_if ();

  // ----------------------------------------------------------------------
  // Output coding
  // ----------------------------------------------------------------------

  // Picks the bit on a data output for the current slot position
  function automatic logic slot_bit(
    input dasr_link_e       phase,
    input logic [IDX_W-1:0] idx,
    input logic [RES_W-1:0] own,
    input logic [RES_W-1:0] other
  );
    logic [IDX_W-1:0] sel;
    logic             b;
    sel = IDX_LSB - idx;
    b   = 1'b0;
    if (idx >= IDX_MSB && idx <= IDX_LSB) begin
      unique case (phase)
        LK_FIRST:  b = own[sel];
        LK_SECOND: b = other[sel];
        LK_IDLE:   b = 1'b0;
        LK_TAIL:   b = 1'b0;
      endcase
    end
    return b;
  endfunction : slot_bit

  // Front end delivers straight binary; flipping the top bit maps
  // midscale onto zero, so all ones turns into all zeros there
  always_comb begin
    coded_a = res_a;
    coded_b = res_b;
    if (ref_reg.coding_s2) begin
      coded_a[RES_W-1] = ~res_a[RES_W-1];
      coded_b[RES_W-1] = ~res_b[RES_W-1];
    end
  end

  // ----------------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------------

  // Full buffer holds off the front end instead of dropping results
  assign res_if.wr_valid = res_valid;
  assign res_if.wr_data  = {coded_a, coded_b};
  assign res_if.rd_ready = ~ref_reg.hold_fresh & ~ref_reg.frm_seen;

  dasr_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk (ref_clk),
    .rst (sys_rst),
    .s   (res_if.fifo_mp)
  );

  // ----------------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------------

  // Edges of the synchronised frame and done levels
  assign frm_rise  = ref_reg.frm_sync[1] & ~ref_reg.frm_seen;
  assign frm_fall  = ~ref_reg.frm_sync[1] & ref_reg.frm_seen;
  assign done_rise = ref_reg.done_sync[1] & ~ref_reg.done_seen;

  // Next state of the system side
  always_comb begin
    ref_next            = ref_reg;
    ref_next.frm_sync   = {ref_reg.frm_sync[0], lk_reg.active};
    ref_next.done_sync  = {ref_reg.done_sync[0], lk_reg.done};
    ref_next.frm_seen   = ref_reg.frm_sync[1];
    ref_next.done_seen  = ref_reg.done_sync[1];
    ref_next.pair_s1    = channel_pair_select;
    ref_next.pair_s2    = ref_reg.pair_s1;
    ref_next.cfg_s1     = input_config_select;
    ref_next.cfg_s2     = ref_reg.cfg_s1;
    ref_next.coding_s1  = twos_comp_select;
    ref_next.coding_s2  = ref_reg.coding_s1;
    ref_next.conv_start = 1'b0;

    // Frame start: sample, and latch the pair and input mode for it
    if (frm_rise) begin
      ref_next.conv_start = 1'b1;
      ref_next.track_hold = 1'b1;
      ref_next.pair_out   = ref_reg.pair_s2;
      ref_next.single_out = ref_reg.cfg_s2;
      ref_next.hold_fresh = 1'b0;
    end

    // Conversion finished or frame aborted: back to tracking
    if (done_rise || frm_fall) begin
      ref_next.track_hold = 1'b0;
    end

    // Reload the held word only between frames, so the link never
    // catches it mid-change at its first edge
    if (res_if.rd_ready && res_if.rd_valid) begin
      ref_next.hold_word  = res_if.rd_data;
      ref_next.hold_fresh = 1'b1;
    end
  end

  // System side register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ref_reg           <= '0;
      ref_reg.pair_out  <= PAIR_RST;
      ref_reg.hold_word <= HOLD_RST;
    end else begin
      ref_reg <= ref_next;
    end
  end

  // ----------------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------------

  // Frame select comes from the same host logic as the serial clock,
  // so it is read here without synchronisers. The held word is quasi
  // static: it only moves while no frame is open.
  always_comb begin
    lk_next = lk_reg;
    unique case (lk_reg.phase)
      LK_IDLE: begin
        lk_next.phase  = LK_FIRST;
        lk_next.idx    = IDX_START;
        lk_next.word_a = ref_reg.hold_word[WORD_W-1:RES_W];
        lk_next.word_b = ref_reg.hold_word[RES_W-1:0];
        lk_next.active = 1'b1;
      end
      LK_FIRST: begin
        if (lk_reg.idx == IDX_LAST) begin
          lk_next.phase = LK_SECOND;
          lk_next.idx   = '0;
        end else begin
          lk_next.idx = lk_reg.idx + 1'b1;
        end
      end
      LK_SECOND: begin
        if (lk_reg.idx == IDX_LAST) begin
          lk_next.phase = LK_TAIL;
          lk_next.idx   = '0;
        end else begin
          lk_next.idx = lk_reg.idx + 1'b1;
        end
      end
      LK_TAIL: begin
        lk_next.idx = '0;
      end
    endcase

    // Conversion completes on the fourteenth clock of the frame
    if (lk_next.phase == LK_FIRST && lk_next.idx == IDX_DONE) begin
      lk_next.done = 1'b1;
    end

    // Each output leads with its own converter, then the other one
    lk_next.dout_a = slot_bit(lk_next.phase, lk_next.idx,
                              lk_next.word_a, lk_next.word_b);
    lk_next.dout_b = slot_bit(lk_next.phase, lk_next.idx,
                              lk_next.word_b, lk_next.word_a);
  end

  // Falling edges shift; a high frame select clears the frame at once,
  // since the serial clock may stop as soon as the frame is over
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Every output leaves straight from a flip-flop
  assign dout_a            = lk_reg.dout_a;
  assign dout_b            = lk_reg.dout_b;
  assign conv_start        = ref_reg.conv_start;
  assign track_hold        = ref_reg.track_hold;
  assign conv_pair_sel     = ref_reg.pair_out;
  assign conv_single_ended = ref_reg.single_out;
  assign res_ready         = res_if.wr_ready;

endmodule : dasr_readout

`default_nettype wire

// ===== test/dasr_readout_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Port checker for the serial readout
// ------------------------------------------------------------------
module dasr_readout_assertions import dasr_pkg::*; (
  // System clock and reset
  input wire logic                      ref_clk,
  input wire logic                      sys_rst,
  // Serial link
  input wire logic                      link_sclk,
  input wire logic                      cs_n,
  input wire logic                      dout_a,
  input wire logic                      dout_b,
  // Front end control
  input wire logic                      conv_start,
  input wire logic                      track_hold,
  input wire logic [dasr_pkg::PAIR_W-1:0] conv_pair_sel,
  input wire logic                      conv_single_ended
);
  logic [5:0] pos;
  logic [5:0] hold_cnt;

  // Falling edges in the frame; cs_n high clears it like the link state
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) pos <= 6'h00;
    else if (pos != 6'h3f) pos <= pos + 6'h01;
  end

  // Cycles in hold, saturating so a stuck hold is still seen
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !track_hold) hold_cnt <= 6'h00;
    else if (hold_cnt != 6'h3f) hold_cnt <= hold_cnt + 6'h01;
  end

  // Frame start, and a hold that has settled past its latch cycle
  sequence s_start;
    conv_start;
  endsequence
  sequence s_held;
    track_hold [*3];
  endsequence

  start_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_start |-> ##[0:2] track_hold) else $error("hold missing after start");
  start_pulse_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_start |=> !conv_start) else $error("start longer than one cycle");
  pair_stable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_held |-> $stable(conv_pair_sel)) else $error("pair moved in hold");
  mode_stable_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_held |-> $stable(conv_single_ended)) else $error("mode moved in hold");
  hold_bound_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    hold_cnt < 6'd40) else $error("hold not released");
  idle_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cs_n && $past(cs_n) |-> !dout_a && !dout_b) else $error("data outside frame");
  lead_zero_a: assert property (@(posedge link_sclk) disable iff (cs_n)
    pos < 6'h02 |-> !dout_a && !dout_b) else $error("leading bits not zero");
  pad_zero_a: assert property (@(posedge link_sclk) disable iff (cs_n)
    pos inside {[14:17], [30:63]} |-> !dout_a && !dout_b) else $error("pad bits not zero");
  cross_word_a: assert property (@(posedge link_sclk) disable iff (cs_n)
    pos inside {[18:29]} |-> dout_b == $past(dout_a, 16) && dout_a == $past(dout_b, 16))
    else $error("second word not the other result");
endmodule : dasr_readout_assertions

bind dasr_readout dasr_readout_assertions u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .link_sclk(link_sclk), .cs_n(cs_n),
  .dout_a(dout_a), .dout_b(dout_b), .conv_start(conv_start), .track_hold(track_hold),
  .conv_pair_sel(conv_pair_sel), .conv_single_ended(conv_single_ended)
);

`default_nettype wire

// ===== test/dasr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Host serial port; clock idles high and stands still between frames
// ------------------------------------------------------------------
module dasr_host_model (
  // Request from the bench
  input  wire logic        go,
  input  wire logic [5:0]  n_clk,
  // Serial link
  output logic             link_sclk,
  output logic             cs_n,
  input  wire logic        dout_a,
  input  wire logic        dout_b,
  // Collected words, first bit at the top
  output logic [31:0]      word_a,
  output logic [31:0]      word_b,
  output logic             busy
);
  int i;

  // Idle link; a short low pulse at power-up gives the link state and
  // the checker's frame counter a real clearing edge on cs_n
  initial begin
    link_sclk = 1'b1;
    cs_n = 1'b0;
    busy = 1'b0;
    #1 cs_n = 1'b1;
  end

  // One frame; each bit taken just before the falling edge that replaces it
  always @(posedge go) begin
    busy = 1'b1;
    word_a = 32'h0;
    word_b = 32'h0;
    #7 cs_n = 1'b0;
    #25;
    for (i = 0; i < n_clk; i++) begin
      word_a = {word_a[30:0], dout_a};
      word_b = {word_b[30:0], dout_b};
      link_sclk = 1'b0;
      #32 link_sclk = 1'b1;
      #32;
    end
    cs_n = 1'b1;
    busy = 1'b0;
  end
endmodule : dasr_host_model

`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import dasr_pkg::*;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              res_valid = 1'b0;
  logic              go = 1'b0;
  logic              twos_comp_select = 1'b0;
  logic              input_config_select = 1'b0;
  logic [PAIR_W-1:0] channel_pair_select = 3'h0;
  logic [RES_W-1:0]  res_a = 12'h000;
  logic [RES_W-1:0]  res_b = 12'h000;
  logic [5:0]        n_clk = 6'h00;
  logic              link_sclk, cs_n, dout_a, dout_b, res_ready, busy;
  logic              conv_start, track_hold, conv_single_ended;
  logic [PAIR_W-1:0] conv_pair_sel;
  logic [31:0]       word_a, word_b;
  logic [RES_W-1:0]  qa [0:11];
  logic [RES_W-1:0]  qb [0:11];
  int                n_mismatch = 0;
  int                n_checks = 0;
  int                n_acc = 0;
  int                n_start = 0;
  int                n_held = 0;

  // ------------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------------
  always #20 ref_clk = ~ref_clk;

  // Start pulses and hold cycles, taken where the outputs are settled
  always @(negedge ref_clk) begin
    if (conv_start === 1'b1) n_start++;
    if (track_hold === 1'b1) n_held++;
  end

  dasr_readout u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .link_sclk(link_sclk), .cs_n(cs_n),
    .dout_a(dout_a), .dout_b(dout_b), .channel_pair_select(channel_pair_select),
    .input_config_select(input_config_select), .twos_comp_select(twos_comp_select),
    .conv_start(conv_start), .track_hold(track_hold), .conv_pair_sel(conv_pair_sel),
    .conv_single_ended(conv_single_ended), .res_valid(res_valid), .res_ready(res_ready),
    .res_a(res_a), .res_b(res_b));

  dasr_host_model u_host (
    .go(go), .n_clk(n_clk), .link_sclk(link_sclk), .cs_n(cs_n), .dout_a(dout_a),
    .dout_b(dout_b), .word_a(word_a), .word_b(word_b), .busy(busy));

  // Comparisons
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag

  // Single result pair, offered for one cycle without waiting on res_ready
  task automatic push(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    @(negedge ref_clk);
    res_valid = 1'b1;
    res_a = a;
    res_b = b;
    @(negedge ref_clk);
    res_valid = 1'b0;
  endtask : push

  // One host frame of n clocks; expectation cut from the 32-bit dual word
  task automatic frame(input int n, input logic [2:0] sel, input logic [11:0] a,
                       input logic [11:0] b);
    logic [31:0] ea;
    logic [31:0] eb;
    int          k;
    int          s0;
    int          h0;
    ea = {2'b00, a, 4'h0, b, 2'b00} >> (32 - n);
    eb = {2'b00, b, 4'h0, a, 2'b00} >> (32 - n);
    channel_pair_select = sel;
    input_config_select = sel[0];
    n_clk = 6'(n);
    repeat (4) @(negedge ref_clk);
    s0 = n_start;
    h0 = n_held;
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
    for (k = 0; k < 300 && busy; k++) @(negedge ref_clk);
    check_flag("frame finished", 1'b0, busy);
    repeat (12) @(negedge ref_clk);
    check_flag("one start pulse", 1'b1, (n_start - s0) == 1);
    // Hold spans sclk edges 1 to 14: 13 x 64 ns, about 21 system cycles
    check_flag("hold length", 1'b1, (n_held - h0) inside {[19:23]});
    check_word("dout_a word", ea, word_a);
    check_word("dout_b word", eb, word_b);
    check_word("pair", {29'h0, sel}, {29'h0, conv_pair_sel});
    check_flag("single ended", sel[0], conv_single_ended);
    check_flag("track_hold", 1'b0, track_hold);
  endtask : frame

  // Fill the buffer until refused, then read every pair back in order
  task automatic t_fill_drain();
    int k;
    for (k = 0; k < 12; k++) begin
      qa[k] = (k == 0) ? 12'h000 : 12'h0a0 + 12'(k);
      qb[k] = (k == 0) ? 12'hfff : 12'hf50 - 12'(k);
    end
    for (k = 0; k < 12; k++) begin
      @(negedge ref_clk);
      res_valid = res_ready;
      res_a = qa[n_acc];
      res_b = qb[n_acc];
      if (res_ready === 1'b1) n_acc++;
    end
    @(negedge ref_clk);
    res_valid = 1'b0;
    check_flag("buffer full", 1'b0, res_ready);
    check_flag("fill count", 1'b1, n_acc >= 8 && n_acc <= 10);
    for (k = 0; k < n_acc; k++) begin
      frame((k % 3 == 0) ? 14 : ((k % 3 == 1) ? 16 : 32), 3'(k), qa[k], qb[k]);
    end
    check_flag("ready after drain", 1'b1, res_ready);
  endtask : t_fill_drain

  // Midscale step under twos complement coding
  task automatic t_twos();
    twos_comp_select = 1'b1;
    repeat (4) @(negedge ref_clk);
    push(12'h800, 12'h7ff);
    repeat (10) @(negedge ref_clk);
    frame(16, 3'h2, 12'h000, 12'hfff);
    twos_comp_select = 1'b0;
  endtask : t_twos

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    frame(16, 3'h5, 12'h000, 12'h000);
    t_fill_drain();
    t_twos();
    complete_run();
  end

  // Whole run is about six hundred cycles; ten thousand means a hang
  initial begin
    #400000;
    n_mismatch++;
    $display("Error watchdog expected finished seen timeout");
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
